// File: rtl/fbod_map.vh
// constants for the flash bus host controller
// Notes on behaviour
// R1: read: chip select and output gate low, write strobe high; device drives byte.
// R2: command write: write strobe and chip select low, output gate high.
// R3: write accepted only with chip select, write strobe low and output gate high.
// R4: output gate high means device floats data pins.
// R5: after power-up or reset device starts in array-read mode.
// R6: device returns array data until a write alters the command register.
// R7: command register has no address; it feeds the internal state machine.
// R8: erase covers one sector, several, or all; sector picked by upper address bits. The model keeps only the last sector erased.
// R9: after identification sequence reads return identification codes.
// R10: during program or erase reads return status bits.
// R11: chip select and reset high put device in standby, outputs floating.
// R12: after standby, host waits full chip-select access time before sampling.
// R13: deselecting during program or erase does not stop the operation.
// R14: reset held low aborts operation, floats data, ignores reads and writes.
// R15: reset pulse returns the state machine to array-read mode.
// R16: host should restart operations interrupted by reset.
// R17: reset held low also places device in standby.
// R18: one variant lacks reset pin; standby on chip select only.
// R19: device latches address and data on first rising strobe; commands in order.
`ifndef FBOD_MAP_VH
`define FBOD_MAP_VH
`define FBOD_CLK_NS       40
`define FBOD_ACC_NS       55
`define FBOD_SETUP_NS     30
`define FBOD_WE_NS        30
`define FBOD_HOLD_NS      20
`define FBOD_RP_NS        500
`define FBOD_RH_NS        50
`define FBOD_SYNC_LAG     2
`define FBOD_CYC_MIN(ns)  (((ns) + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_OP_IDLE      2'h0
`define FBOD_OP_READ      2'h1
`define FBOD_OP_WRITE     2'h2
`define FBOD_OP_RESET     2'h3
`endif

// File: rtl/fbod_timer.v
// down counter giving one-cycle done pulse when a nonzero load runs out
`timescale 1ns/1ps
module fbod_timer #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] count,
    output wire         busy,
    output reg          done
);
    reg [W-1:0] cnt_q;
    assign busy = (cnt_q != {W{1'b0}});
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_q <= count;
            end else if (busy) begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                if (cnt_q == {{(W-1){1'b0}}, 1'b1})
                    done <= 1'b1;
            end
        end
    end
endmodule

// File: rtl/fbod_host.v
// host bus controller for a byte-wide asynchronous parallel flash
`timescale 1ns/1ps
`include "fbod_map.vh"
module fbod_host #(
    parameter AW        = 18,
    parameter HAS_RESET = 1
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          req_valid,
    input  wire [1:0]    req_op,
    input  wire [AW-1:0] req_addr,
    input  wire [7:0]    req_wdata,
    output wire          req_ready,
    output reg           rsp_valid,
    output reg  [7:0]    rsp_rdata,
    output reg  [AW-1:0] byte_address_in,
    output reg           chip_sel_n,
    output reg           out_gate_n,
    output reg           wr_strobe_n,
    output reg           hw_reset_n,
    output reg  [7:0]    byte_data_o,
    output reg           byte_data_oe_n,
    input  wire [7:0]    byte_data_i
);
    // third stage shows the pins three edges back and capture is one edge after the count,
    // so the read count adds the lag to the access time
    localparam integer ACC_I   = `FBOD_CYC_MIN(`FBOD_ACC_NS) + `FBOD_SYNC_LAG;
    localparam integer SETUP_I = `FBOD_CYC_MIN(`FBOD_SETUP_NS);
    localparam integer WE_I    = `FBOD_CYC_MIN(`FBOD_WE_NS);
    localparam integer HOLD_I  = `FBOD_CYC_MIN(`FBOD_HOLD_NS);
    localparam integer RP_I    = `FBOD_CYC_MIN(`FBOD_RP_NS);
    localparam integer RH_I    = `FBOD_CYC_MIN(`FBOD_RH_NS);
    // counts worked out wide, then cut to the timer width on purpose
    localparam [5:0]   C_ACC   = ACC_I[5:0];
    localparam [5:0]   C_SETUP = SETUP_I[5:0];
    localparam [5:0]   C_WE    = WE_I[5:0];
    localparam [5:0]   C_HOLD  = HOLD_I[5:0];
    localparam [5:0]   C_RP    = RP_I[5:0];
    localparam [5:0]   C_RH    = RH_I[5:0];

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_RD    = 3'h1;
    localparam [2:0] S_WSET  = 3'h2;
    localparam [2:0] S_WPUL  = 3'h3;
    localparam [2:0] S_WHOLD = 3'h4;
    localparam [2:0] S_RST   = 3'h5;
    localparam [2:0] S_RREC  = 3'h6;

    reg  [2:0] st_q;
    reg  [7:0] din_s1_q;
    reg  [7:0] din_s2_q;
    reg  [7:0] din_s3_q;
    reg        tload;
    reg  [5:0] tcount;
    wire       tbusy;
    wire       tdone;

    fbod_timer #(.W(6)) u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (tload),
        .count (tcount),
        .busy  (tbusy),
        .done  (tdone)
    );

    // one request at a time; nothing queued
    assign req_ready = (st_q == S_IDLE);

    // data pins are asynchronous to clk; only the second stage reads the first
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            din_s3_q <= 8'h00;
        end else begin
            din_s1_q <= byte_data_i;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
        end
    end

    // first phase length of each request kind
    function [5:0] op_count;
        input [1:0] op;
        begin
            case (op)
                `FBOD_OP_READ:  op_count = C_ACC;
                `FBOD_OP_WRITE: op_count = C_SETUP;
                `FBOD_OP_RESET: op_count = C_RP;
                default:        op_count = 6'h00;
            endcase
        end
    endfunction

    // length of the phase that follows a state; zero means no chained phase
    function [5:0] step_count;
        input [2:0] st;
        begin
            case (st)
                S_WSET:  step_count = C_WE;
                S_WPUL:  step_count = C_HOLD;
                S_RST:   step_count = C_RH;
                default: step_count = 6'h00;
            endcase
        end
    endfunction

    always @* begin
        tload  = 1'b0;
        tcount = 6'h00;
        if (st_q == S_IDLE && req_valid) begin
            // a no-op loads zero, so the timer stays idle
            tload  = 1'b1;
            tcount = op_count(req_op);
        end else if (tdone && step_count(st_q) != 6'h00) begin
            // chained phases reload in the cycle their predecessor ends
            tload  = 1'b1;
            tcount = step_count(st_q);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q            <= S_IDLE;
            rsp_valid       <= 1'b0;
            rsp_rdata       <= 8'h00;
            byte_address_in <= {AW{1'b0}};
            chip_sel_n      <= 1'b1;
            out_gate_n      <= 1'b1;
            wr_strobe_n     <= 1'b1;
            hw_reset_n      <= 1'b1;
            byte_data_o     <= 8'h00;
            byte_data_oe_n  <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    // idle: chip deselected, which is standby R11
                    chip_sel_n  <= 1'b1;
                    out_gate_n  <= 1'b1;
                    wr_strobe_n <= 1'b1;
                    if (req_valid) begin
                        byte_address_in <= req_addr;
                        case (req_op)
                            `FBOD_OP_READ: begin
                                chip_sel_n <= 1'b0; // R1
                                out_gate_n <= 1'b0; // R1
                                st_q       <= S_RD;
                            end
                            `FBOD_OP_WRITE: begin
                                byte_data_o    <= req_wdata;
                                byte_data_oe_n <= 1'b0;
                                chip_sel_n     <= 1'b0; // R2
                                st_q           <= S_WSET;
                            end
                            `FBOD_OP_RESET: begin
                                // no-pin variant: reset request just completes R18
                                if (HAS_RESET != 0)
                                    hw_reset_n <= 1'b0; // R14 R15 R17
                                st_q <= S_RST;
                            end
                            default: begin
                                rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RD: begin
                    // full chip-select access plus sync latency before sampling R12
                    // a byte counts once the last two stages agree; a moving bus stretches the read
                    if (!tbusy && din_s2_q == din_s3_q) begin
                        rsp_rdata  <= din_s3_q;
                        rsp_valid  <= 1'b1;
                        chip_sel_n <= 1'b1;
                        out_gate_n <= 1'b1;
                        st_q       <= S_IDLE;
                    end
                end
                S_WSET: begin
                    if (tdone) begin
                        wr_strobe_n <= 1'b0; // R2 R3
                        st_q        <= S_WPUL;
                    end
                end
                S_WPUL: begin
                    // strobe rises first so the device latches on it R19
                    if (tdone) begin
                        wr_strobe_n <= 1'b1;
                        st_q        <= S_WHOLD;
                    end
                end
                S_WHOLD: begin
                    if (tdone) begin
                        chip_sel_n     <= 1'b1;
                        byte_data_oe_n <= 1'b1;
                        rsp_valid      <= 1'b1;
                        st_q           <= S_IDLE;
                    end
                end
                S_RST: begin
                    if (tdone) begin
                        hw_reset_n <= 1'b1;
                        st_q       <= S_RREC;
                    end
                end
                S_RREC: begin
                    // caller re-issues any interrupted sequence after this R16
                    if (tdone) begin
                        rsp_valid <= 1'b1;
                        st_q      <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// File: sim/fbod_flash_model.sv
// behavioural model of the byte-wide flash device facing the host
`timescale 1ns/1ps
module fbod_flash_model #(
    parameter       AW          = 18,
    parameter [7:0] ID_CODE     = 8'h5c, // arbitrary identification value
    parameter [7:0] ERASE_CMD   = 8'h30, // arbitrary sector erase command byte
    parameter [7:0] STATUS_BUSY = 8'ha0, // arbitrary status byte while busy
    parameter       BUSY_NS     = 2000
) (
    input  logic [AW-1:0] byte_address_in,
    input  logic          chip_sel_n,
    input  logic          out_gate_n,
    input  logic          wr_strobe_n,
    input  logic          hw_reset_n,
    input  logic [7:0]    byte_data_o,
    input  logic          byte_data_oe_n,
    output logic [7:0]    bus_level
);
    logic       id_mode  = 1'b0;
    logic       busy_q   = 1'b0;
    logic       erased_q = 1'b0;
    logic [4:0] sector_q = 5'h00;
    logic [7:0] hold_v;
    // reset low also floats the bus, so with a tied-high reset pin standby rests on chip select alone
    wire        drive = !chip_sel_n && !out_gate_n && wr_strobe_n && hw_reset_n;
    wire        in_erased = erased_q && (byte_address_in[AW-1:AW-5] == sector_q);
    wire [7:0]  dev_v = busy_q    ? STATUS_BUSY :
                        id_mode   ? ID_CODE :
                        in_erased ? 8'hff : byte_address_in[7:0] ^ 8'h5a;
    // mode latch has no address; a rising strobe feeds the state machine
    always @(posedge wr_strobe_n or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            id_mode <= 1'b0;
            busy_q  <= 1'b0;
        end else if (!chip_sel_n && out_gate_n) begin
            id_mode <= (bus_level == 8'h90);
            if (bus_level == ERASE_CMD) begin
                sector_q <= byte_address_in[AW-1:AW-5];
                erased_q <= 1'b1;
                busy_q   <= 1'b1;
                // ends on time or on reset, selected or not; a stale end can cut a quick re-erase short
                busy_q   <= #(BUSY_NS) 1'b0;
            end
        end
    end
    always @* begin
        if (!byte_data_oe_n)
            hold_v = byte_data_o;
        else if (drive)
            hold_v = dev_v;
    end
    // floating wire shows the inverse so stale data never passes
    assign bus_level = (!byte_data_oe_n || drive) ? hold_v : ~hold_v;
endmodule

// File: sim/fbod_host_chk.sv
// protocol checker on the flash host controller pins
`timescale 1ns/1ps
module fbod_host_chk #(
    parameter AW        = 18,
    parameter HAS_RESET = 1
) (
    input wire          clk,
    input wire          rst_n,
    input wire          req_valid,
    input wire [1:0]    req_op,
    input wire          req_ready,
    input wire          rsp_valid,
    input wire [AW-1:0] byte_address_in,
    input wire          chip_sel_n,
    input wire          out_gate_n,
    input wire          wr_strobe_n,
    input wire          hw_reset_n,
    input wire [7:0]    byte_data_o,
    input wire          byte_data_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd; req_valid && req_ready && req_op == 2'h1; endsequence
    sequence s_wr; req_valid && req_ready && req_op == 2'h2; endsequence
    sequence s_rst; req_valid && req_ready && req_op == 2'h3; endsequence
    localparam bit NO_PIN = (HAS_RESET == 0);
    sequence s_wr_setup; (!chip_sel_n && wr_strobe_n && !byte_data_oe_n)[*2]; endsequence
    sequence s_wr_low; (!wr_strobe_n)[*2]; endsequence
    sequence s_wr_hold; (!chip_sel_n && wr_strobe_n)[*2]; endsequence
    sequence s_rst_low; (hw_reset_n == NO_PIN)[*7]; endsequence
    AST_RD_LEVELS: assert property (!out_gate_n |-> !chip_sel_n && wr_strobe_n && byte_data_oe_n)
        else $error("read levels wrong");
    AST_WR_LEVELS: assert property (!wr_strobe_n |-> !chip_sel_n && out_gate_n)
        else $error("write levels wrong");
    AST_WR_DRIVE: assert property (!wr_strobe_n |-> !byte_data_oe_n)
        else $error("data not driven in strobe");
    AST_NO_CLASH: assert property (!byte_data_oe_n |-> out_gate_n)
        else $error("host drives while device may drive");
    AST_RD_WAIT: assert property (s_rd |=> (!chip_sel_n && !out_gate_n)[*5] ##1 (rsp_valid && out_gate_n))
        else $error("read access window wrong");
    AST_WR_PULSE: assert property (s_wr |=> s_wr_setup ##1 s_wr_low ##1 s_wr_hold ##1 (rsp_valid && chip_sel_n))
        else $error("write pulse sequence wrong");
    AST_RST_PULSE: assert property (s_rst |=> s_rst_low ##1 s_rst_low ##1 hw_reset_n ##3 rsp_valid)
        else $error("reset pulse width wrong");
    AST_RST_QUIET: assert property (!hw_reset_n |-> chip_sel_n && out_gate_n && wr_strobe_n && byte_data_oe_n)
        else $error("bus active during reset pulse");
    AST_IDLE_STANDBY: assert property (req_ready |-> chip_sel_n && out_gate_n && wr_strobe_n)
        else $error("device selected while idle");
    AST_WR_STABLE: assert property (!wr_strobe_n |-> $stable(byte_address_in) && $stable(byte_data_o))
        else $error("address or data moved in strobe");
endmodule
bind fbod_host fbod_host_chk #(.AW(AW), .HAS_RESET(HAS_RESET)) u_chk (.*);

// File: sim/tb_flash_bus_operation_decoder.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_flash_bus_operation_decoder;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [17:0] req_addr = 18'h0;
    logic [7:0] req_wdata = 8'h0, rsp_rdata, bus_level, q;
    logic req_ready, rsp_valid, chip_sel_n, out_gate_n, wr_strobe_n, hw_reset_n, byte_data_oe_n;
    logic [17:0] byte_address_in;
    logic [7:0] byte_data_o;
    logic nr_reset_n, nr_rsp_valid, nr_low = 1'b0;
    integer mismatches = 0, n_tests = 0;
    always #20 clk = ~clk;
    fbod_host u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .byte_address_in(byte_address_in), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
        .wr_strobe_n(wr_strobe_n), .hw_reset_n(hw_reset_n), .byte_data_o(byte_data_o),
        .byte_data_oe_n(byte_data_oe_n), .byte_data_i(bus_level));
    fbod_flash_model u_dev (.byte_address_in(byte_address_in), .chip_sel_n(chip_sel_n),
        .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .hw_reset_n(hw_reset_n),
        .byte_data_o(byte_data_o), .byte_data_oe_n(byte_data_oe_n), .bus_level(bus_level));
    // variant without a reset pin runs in lockstep; only its pin and completion are watched
    fbod_host #(.HAS_RESET(0)) u_dut_nr (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(), .rsp_valid(nr_rsp_valid), .rsp_rdata(),
        .byte_address_in(), .chip_sel_n(), .out_gate_n(), .wr_strobe_n(), .hw_reset_n(nr_reset_n),
        .byte_data_o(), .byte_data_oe_n(), .byte_data_i(bus_level));
    always @(negedge nr_reset_n) nr_low = 1'b1;
    task automatic chk(input string what, input [7:0] exp, input [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // lat 0 skips the latency compare
    task automatic req(input [1:0] op, input [17:0] a, input [7:0] d, input [7:0] lat);
        integer n;
        n = 0;
        req_valid = 1'b1; req_op = op; req_addr = a; req_wdata = d;
        while (req_ready !== 1'b1 && n < 40) begin @(posedge clk); #1; n++; end
        @(posedge clk); #1;
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin @(posedge clk); #1; n++; end
        chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
        if (lat != 0) chk("latency", lat, n[7:0]);
        q = rsp_rdata;
    endtask
    task t_read_array;
        req(2'h1, 18'h30012, 8'h00, 8'd5);
        chk("array read", 8'h48, q);
    endtask
    task t_id_mode;
        req(2'h2, 18'h00555, 8'h90, 8'd6);
        req(2'h1, 18'h00001, 8'h00, 8'd5);
        chk("id read", 8'h5c, q);
        req(2'h1, 18'h00002, 8'h00, 8'd5);
        chk("id held", 8'h5c, q);
        req(2'h2, 18'h00000, 8'hf0, 8'd6);
        req(2'h1, 18'h000a5, 8'h00, 8'd5);
        chk("array back", 8'hff, q);
    endtask
    task t_erase;
        req(2'h2, 18'h20000, 8'h30, 8'd6);
        req(2'h1, 18'h20011, 8'h00, 8'd5);
        chk("busy status", 8'ha0, q);
        req(2'h1, 18'h00011, 8'h00, 8'd5);
        chk("status after deselect", 8'ha0, q);
        repeat (60) @(posedge clk);
        #1;
        req(2'h1, 18'h21f34, 8'h00, 8'd5);
        chk("erased sector", 8'hff, q);
        req(2'h1, 18'h23f34, 8'h00, 8'd5);
        chk("other sector", 8'h6e, q);
    endtask
    task t_reset_op;
        req(2'h2, 18'h00555, 8'h90, 8'd6);
        req(2'h3, 18'h00000, 8'h00, 8'd17);
        chk("variant done", 8'h01, {7'h00, nr_rsp_valid});
        chk("variant pin idle", 8'h00, {7'h00, nr_low});
        req(2'h1, 18'h3ff5a, 8'h00, 8'd5);
        chk("read after reset", 8'h00, q);
        req(2'h2, 18'h00000, 8'h30, 8'd6);
        req(2'h3, 18'h00000, 8'h00, 8'd17);
        req(2'h1, 18'h3ff5a, 8'h00, 8'd5);
        chk("erase aborted by reset", 8'h00, q);
    endtask
    task results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        t_read_array;
        t_id_mode;
        t_erase;
        t_reset_op;
        results;
    end
    initial begin
        #(40 * 2000);
        mismatches++;
        results;
    end
endmodule
